// [logic/ssi_pkg.sv]
package ssi_pkg;
  // Clock rate and timing figures
  localparam int CLK_MHZ = 250;
  localparam int BEEP_MS = 100;
  localparam int GAP_MS = 100;
  localparam int FLASH_MS = 250;
  localparam int GREEN_BRIEF_MS = 200;
  localparam int BEEP_CYC = BEEP_MS * CLK_MHZ * 1000;
  localparam int GAP_CYC = GAP_MS * CLK_MHZ * 1000;
  localparam int FLASH_CYC = FLASH_MS * CLK_MHZ * 1000;
  localparam int GREEN_BRIEF_CYC = GREEN_BRIEF_MS * CLK_MHZ * 1000;
  // Beep burst counts and tone kinds
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_TWO = 2'h2;
  localparam logic [1:0] CNT_THREE = 2'h3;
  localparam logic TONE_BEEP = 1'b0;
  localparam logic TONE_RAZZ = 1'b1;

  typedef enum {ST_BOOT, ST_FAULT, ST_IDLE, ST_DORMANT, ST_WAKE} ssi_mode_t;

  // Power-up self-test results
  typedef struct packed {
    logic motor;
    logic laser;
    logic elec;
    logic nvm;
  } ssi_fault_t;

  // Indicator drive
  typedef struct packed {
    logic red;
    logic green;
    logic beep;
    logic razz;
  } ssi_ind_t;
endpackage

// [logic/ssi_core.sv]
// Contract
// - Motor fault: flash both, two razz tones
// - Electronic fault: continuous razz, LEDs dark
// - Config store fault: three beeps
// - Idle timeout: laser and LEDs off, IR wakes
// - Red lit exactly while laser on
// - Good decode: green pulse then one beep
// - Green steady while host data pending
// - Red off at scan expiry regardless green
// - Program mode: red steady, green flashing
// - Invalid program code: razz tone
// - Laser off, host wait: green alone
// - Waking from dormancy: green flashes
// - Suppress same symbol until timeout
// - Laser fault: flash red, one razz
// - Power up: both LEDs, one beep
// - Program entry and exit: three beeps
`timescale 1ns/1ns
`default_nettype none
module ssi_core
  import ssi_pkg::*;
#(
  parameter int IDLE_CYC = 32'd500000000,
  parameter int SAME_CYC = 32'd125000000,
  parameter int WAKE_CYC = 32'd250000000,
  parameter int TW = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic selftest_done,
  input wire ssi_fault_t faults,
  input wire logic decode_ok,
  input wire logic [15:0] symbol_hash,
  input wire logic prog_mode,
  input wire logic prog_invalid,
  input wire logic host_pending,
  input wire logic scan_active,
  input wire logic ir_detect,
  input wire logic activity,
  input wire logic [TW-1:0] idle_cfg,
  input wire logic [TW-1:0] same_cfg,
  output logic laser_on,
  output logic scan_enable,
  output logic report_data,
  output logic red_led,
  output logic green_led,
  output logic beeper,
  output logic beep_razz
);
  initial begin
    if (TW < 30 || TW > 32) $error("ssi_core: TW out of range");
  end

  typedef struct packed {
    ssi_mode_t mode;
    logic [TW-1:0] tmr;
    logic [TW-1:0] idle;
    logic [TW-1:0] same;
    logic [TW-1:0] flash;
    logic flash_ph;
    logic [TW-1:0] gpulse;
    logic [1:0] beeps;
    logic tone;
    logic cont_razz;
    logic [TW-1:0] btmr;
    logic bon;
    logic [15:0] last_sym;
    logic prog_d;
    logic ir_s1, ir_s2;
    logic report;
    logic boot_led;
    logic scan_en;
    ssi_ind_t ind;
  } ssi_state_t;

  ssi_state_t s_q, s_d;
  logic good;
  logic burst_idle;

  // Start a burst of beeps, replacing any burst already in progress
  function automatic ssi_state_t start_burst(ssi_state_t s, logic [1:0] n, logic t);
    ssi_state_t r;
    r = s;
    r.beeps = n;
    r.tone = t;
    r.bon = 1'b0;
    r.btmr = '0;
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.report = 1'b0;
    // IR sensor is a pin: two-flop synchroniser
    s_d.ir_s1 = ir_detect;
    s_d.ir_s2 = s_q.ir_s1;
    s_d.prog_d = prog_mode;
    burst_idle = (s_q.beeps == 2'h0);
    // Free-running flash phase
    if (s_q.flash >= TW'(FLASH_CYC - 1)) begin
      s_d.flash = '0;
      s_d.flash_ph = ~s_q.flash_ph;
    end else begin
      s_d.flash = s_q.flash + 1'b1;
    end
    // Beep sequencer: on and gap periods per beep
    if (!burst_idle) begin
      s_d.btmr = s_q.btmr + 1'b1;
      if (!s_q.bon && s_q.btmr >= TW'(GAP_CYC - 1)) begin
        s_d.bon = 1'b1;
        s_d.btmr = '0;
      end else if (s_q.bon && s_q.btmr >= TW'(BEEP_CYC - 1)) begin
        s_d.bon = 1'b0;
        s_d.btmr = '0;
        s_d.beeps = s_q.beeps - 1'b1;
      end
    end
    if (s_q.gpulse != '0) s_d.gpulse = s_q.gpulse - 1'b1;
    // Power-up lamp ends with the brief green pulse
    if (s_q.boot_led && s_q.gpulse == '0) s_d.boot_led = 1'b0;
    if (s_q.same != '0) s_d.same = s_q.same - 1'b1;
    good = 1'b0;
    case (s_q.mode)
      ST_BOOT: begin
        if (selftest_done) begin
          if (faults.elec) begin
            s_d.mode = ST_FAULT;
            s_d.cont_razz = 1'b1;
          end else if (faults.motor) begin
            s_d.mode = ST_FAULT;
            s_d = start_burst(s_d, CNT_TWO, TONE_RAZZ);
          end else if (faults.laser) begin
            s_d.mode = ST_FAULT;
            s_d = start_burst(s_d, CNT_ONE, TONE_RAZZ);
          end else begin
            s_d.mode = ST_IDLE;
            s_d.idle = '0;
            s_d.gpulse = TW'(GREEN_BRIEF_CYC);
            s_d.boot_led = 1'b1;
            if (faults.nvm) s_d = start_burst(s_d, CNT_THREE, TONE_BEEP);
            else s_d = start_burst(s_d, CNT_ONE, TONE_BEEP);
          end
        end
      end
      ST_FAULT: begin
        s_d.mode = ST_FAULT;
      end
      ST_IDLE: begin
        if (activity || decode_ok || scan_active || host_pending || prog_mode) s_d.idle = '0;
        else if (s_q.idle < idle_cfg) s_d.idle = s_q.idle + 1'b1;
        else s_d.mode = ST_DORMANT;
        if (prog_mode != s_q.prog_d) s_d = start_burst(s_d, CNT_THREE, TONE_BEEP);
        else if (prog_mode && decode_ok && prog_invalid) s_d = start_burst(s_d, CNT_ONE, TONE_RAZZ);
        else if (decode_ok && !prog_mode) begin
          good = (symbol_hash != s_q.last_sym) || (s_q.same == '0);
          if (good) begin
            s_d.last_sym = symbol_hash;
            s_d.same = same_cfg;
            s_d.report = 1'b1;
            s_d.gpulse = TW'(FLASH_CYC);
            s_d = start_burst(s_d, CNT_ONE, TONE_BEEP);
          end else begin
            s_d.same = same_cfg;
          end
        end
      end
      ST_DORMANT: begin
        if (s_q.ir_s2) begin
          s_d.mode = ST_WAKE;
          s_d.tmr = '0;
        end
      end
      ST_WAKE: begin
        if (s_q.tmr >= WAKE_CYC[TW-1:0]) begin
          s_d.mode = ST_IDLE;
          s_d.idle = '0;
        end else begin
          s_d.tmr = s_q.tmr + 1'b1;
        end
      end
      default: s_d.mode = ST_BOOT;
    endcase
    // Indicator composition
    s_d.ind = '0;
    case (s_d.mode)
      ST_BOOT: s_d.ind = '0;
      ST_FAULT: begin
        s_d.ind.red = (faults.motor || faults.laser) && !faults.elec && s_q.flash_ph;
        s_d.ind.green = faults.motor && !faults.elec && s_q.flash_ph;
      end
      ST_DORMANT: s_d.ind = '0;
      ST_WAKE: s_d.ind.green = s_q.flash_ph;
      ST_IDLE: begin
        s_d.ind.red = scan_active || prog_mode || s_d.boot_led;
        if (prog_mode) s_d.ind.green = s_q.flash_ph;
        else s_d.ind.green = (s_d.gpulse != '0) || host_pending;
      end
      default: s_d.ind = '0;
    endcase
    s_d.ind.beep = s_d.cont_razz || (s_d.beeps != 2'h0 && s_d.bon);
    s_d.ind.razz = s_d.cont_razz || s_d.tone;
    // Scanning allowed only in normal operation
    s_d.scan_en = (s_d.mode == ST_IDLE);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign laser_on = s_q.ind.red;
  assign scan_enable = s_q.scan_en;
  assign report_data = s_q.report;
  assign red_led = s_q.ind.red;
  assign green_led = s_q.ind.green;
  assign beeper = s_q.ind.beep;
  assign beep_razz = s_q.ind.razz;
endmodule
`default_nettype wire

// [verification/ssi_core_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module ssi_core_chk
  import ssi_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic selftest_done,
  input wire ssi_fault_t faults,
  input wire logic decode_ok,
  input wire logic prog_mode,
  input wire logic prog_invalid,
  input wire logic host_pending,
  input wire logic laser_on,
  input wire logic scan_enable,
  input wire logic report_data,
  input wire logic red_led,
  input wire logic green_led
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Fault and healthy qualifiers
  wire logic elec = selftest_done && faults.elec;
  wire logic ok = selftest_done && faults == 4'h0;
  property p_dark; elec ##1 elec |-> !red_led && !green_led; endproperty
  a_dark: assert property (p_dark) else $error("lamps lit");
  property p_inh; elec ##1 elec |-> !scan_enable && !report_data; endproperty
  a_inh: assert property (p_inh) else $error("scan in fault");
  property p_cause; report_data |-> $past(decode_ok); endproperty
  a_cause: assert property (p_cause) else $error("stray report");
  property p_once; report_data |=> !report_data; endproperty
  a_once: assert property (p_once) else $error("double report");
  property p_red; ok |-> red_led == laser_on; endproperty
  a_red: assert property (p_red) else $error("red vs laser");
  property p_prog; decode_ok && prog_mode && prog_invalid |=> !report_data; endproperty
  a_prog: assert property (p_prog) else $error("bad code sent");
  property p_host; (ok && host_pending && !prog_mode) [*2] |-> green_led; endproperty
  a_host: assert property (p_host) else $error("green not held");
  property p_enab; report_data |-> $past(scan_enable); endproperty
  a_enab: assert property (p_enab) else $error("report unscanned");
endmodule
bind ssi_core ssi_core_chk CHK (.clock, .rstn, .selftest_done, .faults, .decode_ok, .prog_mode, .prog_invalid,
  .host_pending, .laser_on, .scan_enable, .report_data, .red_led, .green_led);
`default_nettype wire

// [verification/ssi_ind_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ssi_ind_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic green_led,
  output logic [7:0] green_rises
);
  logic green_q;
  // Counts green lamp strikes as an eye sees them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      green_q <= 1'b0;
      green_rises <= 8'h0;
    end else begin
      green_q <= green_led;
      green_rises <= green_rises + {7'h0, green_led & ~green_q};
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
  import ssi_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, selftest_done = 1'b1, decode_ok = 1'b0, prog_mode = 1'b0;
  logic prog_invalid = 1'b0, host_pending = 1'b0, scan_active = 1'b0, ir_detect = 1'b0, activity = 1'b1;
  ssi_fault_t faults = 4'h0;
  logic [15:0] symbol_hash = 16'h0;
  logic [31:0] idle_cfg = 32'h3e8, same_cfg = 32'h28;
  logic laser_on, scan_enable, report_data, red_led, green_led, beep_razz;
  logic [7:0] green_rises;
  int mismatches = 0, checks = 0, n;
  logic [15:0] hs[4] = '{16'h1, 16'h1, 16'h2, 16'h2};
  int gp[4] = '{0, 2, 2, 60};
  logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  ssi_core #(.WAKE_CYC(20)) DUT (.clock, .rstn, .selftest_done, .faults, .decode_ok, .symbol_hash, .prog_mode,
    .prog_invalid, .host_pending, .scan_active, .ir_detect, .activity, .idle_cfg, .same_cfg, .laser_on,
    .scan_enable, .report_data, .red_led, .green_led, .beeper(), .beep_razz);
  ssi_ind_model MDL (.clock, .rstn, .green_led, .green_rises);
  // Clock
  always #2 clock = ~clock;
  task automatic chk(string nm, logic s, logic e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %b got %b", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic dec(logic [15:0] h, logic e);
    logic r;
    r = 1'b0;
    symbol_hash <= h;
    decode_ok <= 1'b1;
    @(posedge clock);
    decode_ok <= 1'b0;
    repeat (3) begin
      @(posedge clock);
      r = r | report_data;
    end
    chk("report", r, e);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    chk("boot", red_led & green_led & (green_rises != 8'h0), 1'b1);
    for (int i = 0; i < 4; i++) begin
      repeat (gp[i]) @(posedge clock);
      dec(hs[i], ex[i]);
    end
    prog_mode <= 1'b1;
    prog_invalid <= 1'b1;
    repeat (2) @(posedge clock);
    dec(16'h3, 1'b0);
    chk("razz", beep_razz, 1'b1);
    prog_mode <= 1'b0;
    prog_invalid <= 1'b0;
    host_pending <= 1'b1;
    scan_active <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("green", green_led, 1'b1);
    @(posedge clock);
    host_pending <= 1'b0;
    scan_active <= 1'b0;
    activity <= 1'b0;
    idle_cfg <= 32'h32;
    for (n = 0; n < 300 && (red_led | green_led | laser_on) !== 1'b0; n++) @(posedge clock);
    chk("dark", red_led | green_led | laser_on, 1'b0);
    ir_detect <= 1'b1;
    for (n = 0; n < 300 && scan_enable !== 1'b1; n++) @(posedge clock);
    chk("ready", scan_enable, 1'b1);
    rstn <= 1'b0;
    faults <= 4'h2;
    @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    chk("lamps", red_led | green_led, 1'b0);
    chk("scan", scan_enable, 1'b0);
    dec(16'h9, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
